//--- rtl/mifeu_pkg.sv
// mifeu_pkg: register map, field positions and types of the interrupt
// flag and enable unit; assumes a 32-bit AXI4-Lite bus and one clock
//
// What this block does
// - pin zero edge field: off, rise, fall, both
// - pin one edge field sits in bits 3..2
// - counter, timebase, pin zero flags at 6,5,4
// - counter, timebase, pin zero enables at 3,2,1
// - global enable bit 0 gates every core request
// - unused bits read zero, writes ignored
// - two pins plus counter, timebase, converter sources
// - flags and enables software readable and writable
// - two control registers, one edge register
// - converter flag 4/enable 0, pin one 5/1
// - flag interrupts core only when enabled
// - service clears global enable, other flags keep pending
// - service clears the serviced pin flag
package mifeu_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned IDX_W  = 3;

	// word index of each register, byte address is four times it
	localparam logic [IDX_W-1:0] IDX_EDGE   = 3'h0;
	localparam logic [IDX_W-1:0] IDX_CTRL0  = 3'h1;
	localparam logic [IDX_W-1:0] IDX_CTRL1  = 3'h2;
	localparam logic [IDX_W-1:0] IDX_STATUS = 3'h3;
	localparam logic [IDX_W-1:0] IDX_MASK   = 3'h4;

	// edge select fields
	localparam int unsigned P_EDGE0 = 0;
	localparam int unsigned P_EDGE1 = 2;
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// first control register
	localparam int unsigned P_GIE      = 0;
	localparam int unsigned P_P0_EN    = 1;
	localparam int unsigned P_TB_EN    = 2;
	localparam int unsigned P_CNT_EN   = 3;
	localparam int unsigned P_P0_FLAG  = 4;
	localparam int unsigned P_TB_FLAG  = 5;
	localparam int unsigned P_CNT_FLAG = 6;

	// second control register
	localparam int unsigned P_CONV_EN   = 0;
	localparam int unsigned P_P1_EN     = 1;
	localparam int unsigned P_CONV_FLAG = 4;
	localparam int unsigned P_P1_FLAG   = 5;

	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one bit per source; also the layout of the status and mask words
	typedef struct packed {
		logic pin_one;
		logic converter;
		logic counter;
		logic timebase;
		logic pin_zero;
	} mifeu_src_t;

	localparam int unsigned SRC_N = 5;

	// source presented to the core, listed in falling priority
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_PIN_ZERO,
		SRC_TIMEBASE,
		SRC_COUNTER,
		SRC_CONVERTER,
		SRC_PIN_ONE
	} mifeu_src_id_t;
endpackage : mifeu_pkg

//--- rtl/mifeu_edge_detect.sv
// mifeu_edge_detect: synchronises external pins and reports selected edges
// assumes pins are asynchronous to sys_clk_in; one-cycle pulses out
`timescale 1ns/10ps
module mifeu_edge_detect #(
	parameter int PINS = 2
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_b_in,
	input  wire logic [PINS-1:0]   pin_in,
	input  wire logic [2*PINS-1:0] edge_sel_in,
	output logic      [PINS-1:0]   edge_out
);
	logic [PINS-1:0] meta;
	logic [PINS-1:0] sync;
	logic [PINS-1:0] prev;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
		end else begin
			meta <= pin_in;
			sync <= meta;
			prev <= sync;
		end
	end

	for (genvar i = 0; i < PINS; i++) begin : g_pin
		logic [1:0] sel;
		logic       rise;
		logic       fall;
		assign sel  = edge_sel_in[2*i +: 2];
		assign rise = sync[i] & ~prev[i];
		assign fall = ~sync[i] & prev[i];
		assign edge_out[i] =
			(rise && (sel == mifeu_pkg::EDGE_RISE ||
			          sel == mifeu_pkg::EDGE_BOTH)) ||
			(fall && (sel == mifeu_pkg::EDGE_FALL ||
			          sel == mifeu_pkg::EDGE_BOTH));

		edge_off_a: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			(sel == mifeu_pkg::EDGE_OFF) |-> !edge_out[i])
			else $error("edge reported while field is off");

		one_pulse_a: assert property (
			@(posedge sys_clk_in) disable iff (!rst_b_in)
			(edge_out[i] && sel != mifeu_pkg::EDGE_BOTH) |=>
			(!edge_out[i] || sel != $past(sel)))
			else $error("edge pulse longer than one cycle");
	end
endmodule : mifeu_edge_detect

//--- rtl/mifeu_top.sv
// mifeu_top: interrupt flags, enables, edge selects and core request
// assumes an AXI4-Lite master, one-cycle source event pulses and a core
// that pulses core_irq_ack_in when it vectors to core_irq_src_out
`timescale 1ns/10ps
module mifeu_top #(
	parameter bit TWO_PINS = 1'b1
) (
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_b_in,
	input  wire logic [4:0]                s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	output logic [1:0]                     s_axi_bresp_out,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	input  wire logic [4:0]                s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	output logic [31:0]                    s_axi_rdata_out,
	output logic [1:0]                     s_axi_rresp_out,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	input  wire logic                      ext_pin_zero_in,
	input  wire logic                      ext_pin_one_in,
	input  wire logic                      counter_event_in,
	input  wire logic                      timebase_event_in,
	input  wire logic                      converter_event_in,
	input  wire logic                      core_irq_ack_in,
	output logic                           core_irq_req_out,
	output mifeu_pkg::mifeu_src_id_t       core_irq_src_out,
	output logic                           sys_irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	localparam int unsigned IW = mifeu_pkg::IDX_W;

	logic                     aw_held;
	logic                     w_held;
	logic [IW-1:0]            aw_idx;
	logic [31:0]              w_data;
	logic                     w_lane;
	logic                     wr_fire;
	logic                     wr_edge;
	logic                     wr_c0;
	logic                     wr_c1;
	logic                     wr_st;
	logic                     wr_mask;
	logic                     wr_hit;
	logic [IW-1:0]            rd_idx;
	logic [31:0]              rd_word;
	logic                     rd_hit;

	logic [3:0]               edge_sel;
	logic                     global_en;
	mifeu_pkg::mifeu_src_t    flags;
	mifeu_pkg::mifeu_src_t    en;
	mifeu_pkg::mifeu_src_t    status;
	mifeu_pkg::mifeu_src_t    mask;
	mifeu_pkg::mifeu_src_t    set_ev;
	mifeu_pkg::mifeu_src_t    wr_sel;
	mifeu_pkg::mifeu_src_t    wr_val;
	mifeu_pkg::mifeu_src_t    ack_clr;
	mifeu_pkg::mifeu_src_t    pend;
	logic [1:0]               pin_edge;
	logic                     ack_take;
	logic                     next_req;
	mifeu_pkg::mifeu_src_id_t next_src;

	// ---------------- AXI4-Lite slave ----------------
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			aw_held <= 1'b0;
			aw_idx  <= '0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held <= 1'b1;
			aw_idx  <= s_axi_awaddr_in[4:2];
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_lane <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_in;
			w_lane <= s_axi_wstrb_in[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		wr_edge = wr_fire && w_lane && aw_idx == mifeu_pkg::IDX_EDGE;
		wr_c0   = wr_fire && w_lane && aw_idx == mifeu_pkg::IDX_CTRL0;
		wr_c1   = wr_fire && w_lane && aw_idx == mifeu_pkg::IDX_CTRL1;
		wr_st   = wr_fire && w_lane && aw_idx == mifeu_pkg::IDX_STATUS;
		wr_mask = wr_fire && w_lane && aw_idx == mifeu_pkg::IDX_MASK;
		wr_hit  = aw_idx <= mifeu_pkg::IDX_MASK;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= mifeu_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= wr_hit ? mifeu_pkg::RESP_OKAY
			                           : mifeu_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	assign rd_idx = s_axi_araddr_in[4:2];

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (rd_idx)
			mifeu_pkg::IDX_EDGE:
				rd_word[3:0] = edge_sel;
			mifeu_pkg::IDX_CTRL0: begin
				rd_word[mifeu_pkg::P_GIE]      = global_en;
				rd_word[mifeu_pkg::P_P0_EN]    = en.pin_zero;
				rd_word[mifeu_pkg::P_TB_EN]    = en.timebase;
				rd_word[mifeu_pkg::P_CNT_EN]   = en.counter;
				rd_word[mifeu_pkg::P_P0_FLAG]  = flags.pin_zero;
				rd_word[mifeu_pkg::P_TB_FLAG]  = flags.timebase;
				rd_word[mifeu_pkg::P_CNT_FLAG] = flags.counter;
			end
			mifeu_pkg::IDX_CTRL1: begin
				rd_word[mifeu_pkg::P_CONV_EN]   = en.converter;
				rd_word[mifeu_pkg::P_P1_EN]     = en.pin_one;
				rd_word[mifeu_pkg::P_CONV_FLAG] = flags.converter;
				rd_word[mifeu_pkg::P_P1_FLAG]   = flags.pin_one;
			end
			mifeu_pkg::IDX_STATUS:
				rd_word[mifeu_pkg::SRC_N-1:0] = status;
			mifeu_pkg::IDX_MASK:
				rd_word[mifeu_pkg::SRC_N-1:0] = mask;
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= '0;
			s_axi_rresp_out  <= mifeu_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out  <= rd_word;
			s_axi_rresp_out  <= rd_hit ? mifeu_pkg::RESP_OKAY
			                           : mifeu_pkg::RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// ---------------- edge selection ----------------
	// pin one field exists only on the two-pin variant
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			edge_sel <= mifeu_pkg::REG_RST[3:0];
		end else if (wr_edge) begin
			edge_sel[mifeu_pkg::P_EDGE0 +: 2] <=
				w_data[mifeu_pkg::P_EDGE0 +: 2];
			edge_sel[mifeu_pkg::P_EDGE1 +: 2] <= TWO_PINS ?
				w_data[mifeu_pkg::P_EDGE1 +: 2] : mifeu_pkg::EDGE_OFF;
		end
	end

	mifeu_edge_detect #(
		.PINS        (2)
	) u_edge (
		.sys_clk_in  (sys_clk_in),
		.rst_b_in    (rst_b_in),
		.pin_in      ({ext_pin_one_in, ext_pin_zero_in}),
		.edge_sel_in (edge_sel),
		.edge_out    (pin_edge)
	);

	// ---------------- flags and enables ----------------
	assign ack_take = core_irq_ack_in && core_irq_req_out;

	always_comb begin
		set_ev.pin_zero  = pin_edge[0];
		set_ev.pin_one   = pin_edge[1] && TWO_PINS;
		set_ev.counter   = counter_event_in;
		set_ev.timebase  = timebase_event_in;
		set_ev.converter = converter_event_in;
		wr_sel.pin_zero  = wr_c0;
		wr_sel.timebase  = wr_c0;
		wr_sel.counter   = wr_c0;
		wr_sel.converter = wr_c1;
		wr_sel.pin_one   = wr_c1 && TWO_PINS;
		wr_val.pin_zero  = w_data[mifeu_pkg::P_P0_FLAG];
		wr_val.timebase  = w_data[mifeu_pkg::P_TB_FLAG];
		wr_val.counter   = w_data[mifeu_pkg::P_CNT_FLAG];
		wr_val.converter = w_data[mifeu_pkg::P_CONV_FLAG];
		wr_val.pin_one   = w_data[mifeu_pkg::P_P1_FLAG];
		ack_clr.pin_zero  = ack_take && core_irq_src_out ==
		                    mifeu_pkg::SRC_PIN_ZERO;
		ack_clr.timebase  = ack_take && core_irq_src_out ==
		                    mifeu_pkg::SRC_TIMEBASE;
		ack_clr.counter   = ack_take && core_irq_src_out ==
		                    mifeu_pkg::SRC_COUNTER;
		ack_clr.converter = ack_take && core_irq_src_out ==
		                    mifeu_pkg::SRC_CONVERTER;
		ack_clr.pin_one   = ack_take && core_irq_src_out ==
		                    mifeu_pkg::SRC_PIN_ONE;
	end

	// hardware set wins over software or service clear
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in)
			flags <= '0;
		else
			flags <= set_ev | (wr_sel & wr_val) |
			         (~wr_sel & ~ack_clr & flags);
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			en <= '0;
		end else begin
			if (wr_c0) begin
				en.pin_zero <= w_data[mifeu_pkg::P_P0_EN];
				en.timebase <= w_data[mifeu_pkg::P_TB_EN];
				en.counter  <= w_data[mifeu_pkg::P_CNT_EN];
			end
			if (wr_c1) begin
				en.converter <= w_data[mifeu_pkg::P_CONV_EN];
				en.pin_one   <= w_data[mifeu_pkg::P_P1_EN] && TWO_PINS;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in)
			global_en <= 1'b0;
		else if (wr_c0)
			global_en <= w_data[mifeu_pkg::P_GIE];
		else if (ack_take)
			global_en <= 1'b0;
	end

	// ---------------- core request ----------------
	// only enabled flags count
	assign pend = flags & en;

	always_comb begin
		next_src = mifeu_pkg::SRC_NONE;
		if (pend.pin_zero)
			next_src = mifeu_pkg::SRC_PIN_ZERO;
		else if (pend.timebase)
			next_src = mifeu_pkg::SRC_TIMEBASE;
		else if (pend.counter)
			next_src = mifeu_pkg::SRC_COUNTER;
		else if (pend.converter)
			next_src = mifeu_pkg::SRC_CONVERTER;
		else if (pend.pin_one)
			next_src = mifeu_pkg::SRC_PIN_ONE;
		next_req = global_en && (|pend) && !ack_take;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			core_irq_req_out <= 1'b0;
			core_irq_src_out <= mifeu_pkg::SRC_NONE;
		end else begin
			core_irq_req_out <= next_req;
			core_irq_src_out <= next_req ? next_src
			                             : mifeu_pkg::SRC_NONE;
		end
	end

	// ---------------- system interrupt ----------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			status <= '0;
			mask   <= '0;
		end else begin
			status <= set_ev | (status &
			          ~(wr_st ? w_data[mifeu_pkg::SRC_N-1:0] : '0));
			if (wr_mask)
				mask <= w_data[mifeu_pkg::SRC_N-1:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in)
			sys_irq_out <= 1'b0;
		else
			sys_irq_out <= |(status & mask);
	end

	// ---------------- checks ----------------
	gie_gate_a: assert property (
		!global_en |=> !core_irq_req_out)
		else $error("core request while global enable is low");

	enable_gate_a: assert property (
		core_irq_req_out |-> $past(|(flags & en)))
		else $error("core request without an enabled flag");

	ack_gie_a: assert property (
		(ack_take && !wr_c0) |=> (!global_en && !core_irq_req_out))
		else $error("service left global enable set");

	ack_pin_a: assert property (
		(ack_take && core_irq_src_out == mifeu_pkg::SRC_PIN_ZERO &&
		 !set_ev.pin_zero && !wr_c0) |=> !flags.pin_zero)
		else $error("serviced pin flag not cleared");

	set_wins_a: assert property (
		set_ev.counter |=> flags.counter)
		else $error("counter event lost");

	conv_flag_a: assert property (
		set_ev.converter |=> (flags.converter && status.converter))
		else $error("converter event not recorded");

	reset_clear_a: assert property (
		$past(!rst_b_in) |-> (flags == '0 && en == '0 &&
		 !global_en && edge_sel == '0))
		else $error("state not cleared by reset");

	reserved_zero_a: assert property (
		s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == '0)
		else $error("unimplemented bits read nonzero");

	pending_hold_a: assert property (
		(flags.timebase && !global_en && !wr_c0 && !ack_clr.timebase)
		|=> flags.timebase)
		else $error("pending flag dropped while blocked");
endmodule : mifeu_top

//--- tb/mifeu_core_model.sv
// mifeu_core_model: processor core stand-in that vectors and acknowledges
// assumes registered request and source outputs of the interrupt unit
`timescale 1ns/10ps
module mifeu_core_model (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_b_in,
	input  wire logic                     req_in,
	input  wire mifeu_pkg::mifeu_src_id_t src_in,
	input  wire logic [3:0]               delay_in,
	output logic                          ack_out,
	output mifeu_pkg::mifeu_src_id_t      taken_src_out,
	output logic [7:0]                    taken_count_out
);
	logic [3:0] wait_cnt;

	// one-cycle acknowledge after delay_in cycles of pending request
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			ack_out <= 1'h0;
			wait_cnt <= 4'h0;
			taken_src_out <= mifeu_pkg::SRC_NONE;
			taken_count_out <= 8'h00;
		end else if (ack_out) begin
			ack_out <= 1'h0;
			wait_cnt <= 4'h0;
		end else if (req_in && wait_cnt == delay_in) begin
			ack_out <= 1'h1;
			taken_src_out <= src_in;
			taken_count_out <= taken_count_out + 8'h01;
		end else if (req_in) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
		end
	end
endmodule : mifeu_core_model

//--- tb/mcu_interrupt_flag_enable_unit_test.sv
// testbench of the interrupt flag and enable unit with a core model
// assumes the unit's AXI4-Lite slave timing and one 100 MHz clock
`timescale 1ns/10ps
module mcu_interrupt_flag_enable_unit_test;
	localparam logic [4:0] A_EDGE = {mifeu_pkg::IDX_EDGE, 2'h0};
	localparam logic [4:0] A_C0   = {mifeu_pkg::IDX_CTRL0, 2'h0};
	localparam logic [4:0] A_C1   = {mifeu_pkg::IDX_CTRL1, 2'h0};
	localparam logic [4:0] A_STAT = {mifeu_pkg::IDX_STATUS, 2'h0};
	localparam logic [4:0] A_MASK = {mifeu_pkg::IDX_MASK, 2'h0};
	logic                     sys_clk_in, rst_b_in;
	logic [4:0]               awaddr, araddr, f, e, r, m;
	logic                     awvalid, wvalid, bready, arvalid, rready;
	logic                     awready, wready, bvalid, arready, rvalid;
	logic [31:0]              wdata, rdata, got, x;
	logic [3:0]               wstrb, delay;
	logic [1:0]               bresp, rresp, resp, md0, md1;
	logic                     pin0, pin1, cnt_ev, tb_ev, conv_ev;
	logic                     ack, req, sys_irq;
	mifeu_pkg::mifeu_src_id_t src, taken;
	logic [7:0]               taken_n, n_prev;
	int                       fail_count, n_tests, cycles, k;

	mifeu_top DUT (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .ext_pin_zero_in(pin0),
		.ext_pin_one_in(pin1), .counter_event_in(cnt_ev),
		.timebase_event_in(tb_ev), .converter_event_in(conv_ev),
		.core_irq_ack_in(ack), .core_irq_req_out(req),
		.core_irq_src_out(src), .sys_irq_out(sys_irq));

	mifeu_core_model core (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.req_in(req), .src_in(src), .delay_in(delay), .ack_out(ack),
		.taken_src_out(taken), .taken_count_out(taken_n));

	initial begin
		sys_clk_in = 1'h0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			finish_test();
		end
	end

	task finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	task check(input logic [31:0] g, input logic [31:0] xp);
		n_tests++;
		if (g !== xp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, xp);
		end
	endtask : check

	task axi_write(input logic [4:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge sys_clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		b_t = 1'h0;
		while (!b_t) begin
			@(negedge sys_clk_in);
			aw_t = awvalid & awready;
			w_t = wvalid & wready;
			b_t = bvalid & bready;
			resp = bresp;
			@(posedge sys_clk_in);
			if (aw_t) awvalid <= 1'h0;
			if (w_t) wvalid <= 1'h0;
			if (b_t) bready <= 1'h0;
		end
	endtask : axi_write

	task axi_read(input logic [4:0] a);
		logic ar_t, r_t;
		@(posedge sys_clk_in);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		r_t = 1'h0;
		while (!r_t) begin
			@(negedge sys_clk_in);
			ar_t = arvalid & arready;
			r_t = rvalid & rready;
			got = rdata;
			resp = rresp;
			@(posedge sys_clk_in);
			if (ar_t) arvalid <= 1'h0;
			if (r_t) rready <= 1'h0;
		end
	endtask : axi_read

	task rd_chk(input logic [4:0] a, input logic [31:0] xp);
		axi_read(a);
		check(got, xp);
	endtask : rd_chk

	function automatic logic [31:0] c0(input logic [4:0] fl,
		input logic [4:0] en, input logic g);
		return {25'h0, fl[2], fl[1], fl[0], en[2], en[1], en[0], g};
	endfunction : c0

	function automatic logic [31:0] c1(input logic [4:0] fl,
		input logic [4:0] en);
		return {26'h0, fl[4], fl[3], 2'h0, en[4], en[3]};
	endfunction : c1

	// highest priority pending source, as the core should see it
	function automatic logic [31:0] first_src(input logic [4:0] v);
		for (int i = 0; i < 5; i++) if (v[i]) return 32'(i + 1);
		return 32'h0;
	endfunction : first_src

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{pin0, pin1, cnt_ev, tb_ev, conv_ev} = 5'h00;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		delay = 4'h0;
		rst_b_in = 1'h0;
		k = $urandom(32'h5C69EB8F);
		repeat (20) @(posedge sys_clk_in);
		rst_b_in <= 1'h1;
		for (k = 0; k < 5; k++) rd_chk(5'(k * 4), 32'h0);
		rd_chk(5'h14, 32'h0);
		check(32'(resp), 32'(mifeu_pkg::RESP_SLVERR));
		axi_write(5'h18, 32'hFF);
		check(32'(resp), 32'(mifeu_pkg::RESP_SLVERR));
		axi_write(A_EDGE, 32'hFFFFFFFF);
		rd_chk(A_EDGE, 32'h0F);
		axi_write(A_C0, 32'hFFFFFFFE);
		rd_chk(A_C0, 32'h7E);
		axi_write(A_C1, 32'hFFFFFFFF);
		rd_chk(A_C1, 32'h33);
		axi_write(A_C0, 32'h0);
		axi_write(A_C1, 32'h0);
		wstrb <= 4'h0;
		axi_write(A_MASK, 32'hFF);
		wstrb <= 4'hF;
		rd_chk(A_MASK, 32'h0);
		// every edge mode, pin one offset by one mode
		for (k = 0; k < 4; k++) begin
			md0 = 2'(k);
			md1 = md0 + 2'h1;
			axi_write(A_EDGE, {28'h0, md1, md0});
			pin0 <= 1'h1;
			pin1 <= 1'h1;
			repeat (6) @(posedge sys_clk_in);
			rd_chk(A_C0, {27'h0, md0[0], 4'h0});
			rd_chk(A_C1, {26'h0, md1[0], 5'h0});
			axi_write(A_C0, 32'h0);
			axi_write(A_C1, 32'h0);
			pin0 <= 1'h0;
			pin1 <= 1'h0;
			repeat (6) @(posedge sys_clk_in);
			rd_chk(A_C0, {27'h0, md0[1], 4'h0});
			rd_chk(A_C1, {26'h0, md1[1], 5'h0});
			axi_write(A_C0, 32'h0);
			axi_write(A_C1, 32'h0);
		end
		axi_write(A_EDGE, 32'h0F);
		// random sources, enables, mask and core response time
		for (k = 0; k < 8; k++) begin
			r = 5'($urandom);
			e = 5'($urandom);
			m = 5'($urandom);
			delay <= 4'($urandom);
			f = r;
			axi_write(A_STAT, 32'h1F);
			axi_write(A_MASK, 32'(m));
			axi_write(A_C0, c0(5'h0, e, 1'h0));
			axi_write(A_C1, c1(5'h0, e));
			pin0 <= pin0 ^ r[0];
			pin1 <= pin1 ^ r[4];
			tb_ev <= r[1];
			cnt_ev <= r[2];
			conv_ev <= r[3];
			@(posedge sys_clk_in);
			{tb_ev, cnt_ev, conv_ev} <= 3'h0;
			repeat (8) @(posedge sys_clk_in);
			@(negedge sys_clk_in);
			check(32'(req), 32'h0);
			check(32'(sys_irq), 32'(|(r & m)));
			rd_chk(A_STAT, 32'(r));
			while ((f & e) != 5'h0) begin
				n_prev = taken_n;
				x = first_src(f & e);
				axi_write(A_C0, c0(f, e, 1'h1));
				while (taken_n == n_prev) @(negedge sys_clk_in);
				check(32'(taken), x);
				f[x[2:0] - 3'h1] = 1'h0;
				rd_chk(A_C0, c0(f, e, 1'h0));
				rd_chk(A_C1, c1(f, e));
			end
			axi_write(A_C0, c0(f, e, 1'h1));
			repeat (6) @(posedge sys_clk_in);
			@(negedge sys_clk_in);
			check(32'(req), 32'h0);
			rd_chk(A_C0, c0(f, e, 1'h1));
			axi_write(A_C0, 32'h0);
			axi_write(A_C1, 32'h0);
		end
		finish_test();
	end
endmodule : mcu_interrupt_flag_enable_unit_test
